// ==== lsc_ctrl.sv ====
// digital control of a four-channel lamp switch: wake, sleep, direct inputs,
// fault flag, 16-bit serial port, watchdog fail-safe and sense selection
// assumes every pin input is asynchronous and slow against i_ref_clk
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - any direct input wakes the device
// - direct input n drives output n
// - external PWM clock taken from direct input zero
// - fault flag pulled low while fault detected
// - fault causes reported only on serial output
// - wake pin brings device out of sleep
// - reset low clears configuration, faults, enters sleep
// - reset wakes; its rising edge starts watchdog
// - frames are exactly sixteen bits
// - sense output selects channel current or temperature
// - sense output can be tri-stated
// - each output from direct input or serial settings
// - trip levels and inrush duration programmable
// - fail-safe keeps outputs under direct input control
// - commit on select rise, load status on fall
// - sample on falling clock, shift out on rising
// - frames run most significant bit first
// - select high ignores clock, tri-states output
module lsc_ctrl
#(
  parameter int WDOG_CYCLES = lsc_pkg::WDOG_CYCLES
)
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [3:0] i_direct_input,
  input  wire logic       i_wake,
  input  wire logic       i_reset_pin_n,
  input  wire logic       i_cs_n,
  input  wire logic       i_sclk,
  input  wire logic       i_sdi,
  input  wire logic       i_fsi,
  input  wire logic [3:0] i_fault,
  output logic [3:0]      o_high_side_outputs,
  output logic            o_fault_flag_n_o,
  output logic            o_fault_flag_n_oe,
  output logic            o_sdo,
  output logic            o_sdo_oe,
  output logic [1:0]      o_sense_chan,
  output logic            o_sense_temp,
  output logic            o_current_sense_out_oe,
  output logic [3:0]      o_trip_level,
  output logic [7:0]      o_inrush_time,
  output logic            o_pwm_clk,
  output logic            o_awake,
  output logic            o_failsafe
);

  lsc_pkg::lsc_pins_t  p;
  lsc_pkg::lsc_state_t s;
  lsc_pkg::lsc_state_t next_s;
  logic [15:0]         status;
  logic [4:0]          addr;
  logic                sclk_fall;
  logic                sclk_rise;
  logic                cs_fall;
  logic                cs_rise;
  logic                rst_rise;
  logic                rst_fall;
  logic                frame_ok;

  // select idles high; a low reset value would switch the serial output on after reset
  localparam lsc_pkg::lsc_pins_t PINS_IDLE = '{din: 4'h0, wake: 1'b0, rst_pin: 1'b0,
                                               cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0,
                                               fsi: 1'b1, fault: 4'h0};

  lsc_sync #(.WIDTH($bits(lsc_pkg::lsc_pins_t)), .RST_VAL(PINS_IDLE)) u_sync
  (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_direct_input, i_wake, i_reset_pin_n, i_cs_n, i_sclk, i_sdi, i_fsi,
                 i_fault}),
    .o_sync    (p)
  );

  assign sclk_fall = s.sclk_prev & ~p.sclk & ~p.cs_n;
  assign sclk_rise = ~s.sclk_prev & p.sclk & ~p.cs_n;
  assign cs_fall   = s.cs_prev & ~p.cs_n;
  assign cs_rise   = ~s.cs_prev & p.cs_n;
  assign rst_rise  = ~s.rst_prev & p.rst_pin;
  assign rst_fall  = s.rst_prev & ~p.rst_pin;
  // a frame counts only with exactly sixteen clocks and reset released
  assign frame_ok  = cs_rise && (s.bitcnt == 5'(lsc_pkg::FRAME_BITS)) && p.rst_pin;
  assign addr      = s.shift[lsc_pkg::ADDR_MSB:lsc_pkg::ADDR_LSB];
  // individual fault causes leave only through this word
  assign status    = {s.fault_lat, s.hs, s.failsafe, s.awake, p.din, 2'h0};

  always_comb
  begin
    next_s           = s;
    next_s.rst_prev  = p.rst_pin;
    next_s.sclk_prev = p.sclk;
    next_s.cs_prev   = p.cs_n;

    // wake sources; reset falling forces sleep and wins
    if (rst_fall)
      next_s.awake = 1'b0;
    else if ((|p.din) || p.wake || rst_rise)
      next_s.awake = 1'b1;

    // serial port; clock and data ignored while select is high
    next_s.sdo_oe = ~p.cs_n;
    if (cs_fall)
    begin
      next_s.sout   = status;
      next_s.sdo    = status[15];
      next_s.bitcnt = 5'h00;
    end
    else if (sclk_fall)
    begin
      next_s.shift = {s.shift[14:0], p.sdi};
      if (s.bitcnt != 5'h1F)
        next_s.bitcnt = s.bitcnt + 5'h01;
    end
    else if (sclk_rise)
    begin
      next_s.sout = {s.sout[14:0], 1'b0};
      next_s.sdo  = s.sout[14];
    end

    if (frame_ok)
    begin
      unique case (addr)
        lsc_pkg::ADDR_OUT_CTRL:
        begin
          next_s.cfg.spi_on     = s.shift[lsc_pkg::OUT_ON_LSB +: 4];
          next_s.cfg.direct_sel = s.shift[lsc_pkg::OUT_DIRECT_LSB +: 4];
          next_s.cfg.ext_clk    = s.shift[lsc_pkg::OUT_EXTCLK_BIT];
        end
        lsc_pkg::ADDR_SENSE:
        begin
          next_s.cfg.sense_chan = s.shift[lsc_pkg::SENSE_CHAN_LSB +: 2];
          next_s.cfg.sense_temp = s.shift[lsc_pkg::SENSE_TEMP_BIT];
          next_s.cfg.sense_en   = s.shift[lsc_pkg::SENSE_EN_BIT];
        end
        lsc_pkg::ADDR_TRIP:
          next_s.cfg.trip = s.shift[lsc_pkg::TRIP_LSB +: 4];
        lsc_pkg::ADDR_INRUSH:
          next_s.cfg.inrush = s.shift[lsc_pkg::INRUSH_LSB +: 8];
        default:
          next_s.cfg = s.cfg;
      endcase
    end

    // watchdog: any good frame refreshes it and leaves fail-safe
    if (rst_rise)
    begin
      next_s.wd_run = 1'b1;
      next_s.wd_cnt = '0;
    end
    else if (frame_ok)
    begin
      next_s.wd_cnt   = '0;
      next_s.failsafe = 1'b0;
    end
    else if (s.wd_run && p.fsi)
    begin
      if (s.wd_cnt >= 32'(WDOG_CYCLES - 1))
        next_s.failsafe = 1'b1;
      else
        next_s.wd_cnt = s.wd_cnt + 32'h1;
    end

    // sticky fault causes, set wins over everything but the reset pin
    next_s.fault_lat = s.fault_lat | p.fault;
    next_s.ff_oe     = |p.fault;

    if (!p.rst_pin)
    begin
      next_s.cfg       = lsc_pkg::CFG_RESET;
      next_s.fault_lat = 4'h0;
      next_s.wd_run    = 1'b0;
      next_s.wd_cnt    = '0;
      next_s.failsafe  = 1'b0;
      next_s.hs        = 4'h0;
    end
    else if (!s.awake)
      next_s.hs = 4'h0;
    else if (s.failsafe)
      next_s.hs = p.din;
    else
    begin
      for (int n = 0; n < 4; n++)
      begin
        // input zero carries the PWM clock when external clock is chosen
        if (s.cfg.direct_sel[n] && !(n == 0 && s.cfg.ext_clk))
          next_s.hs[n] = p.din[n];
        else
          next_s.hs[n] = s.cfg.spi_on[n];
      end
    end
    next_s.pwm_clk = s.cfg.ext_clk & p.din[0];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign o_high_side_outputs    = s.hs;
  assign o_fault_flag_n_o       = 1'b0;
  assign o_fault_flag_n_oe      = s.ff_oe;
  assign o_sdo                  = s.sdo;
  assign o_sdo_oe               = s.sdo_oe;
  assign o_sense_chan           = s.cfg.sense_chan;
  assign o_sense_temp           = s.cfg.sense_temp;
  assign o_current_sense_out_oe = s.cfg.sense_en;
  assign o_trip_level           = s.cfg.trip;
  assign o_inrush_time          = s.cfg.inrush;
  assign o_pwm_clk              = s.pwm_clk;
  assign o_awake                = s.awake;
  assign o_failsafe             = s.failsafe;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  sequence seq_good_frame;
    frame_ok;
  endsequence

  sequence seq_sense_write;
    seq_good_frame ##0 (addr == lsc_pkg::ADDR_SENSE);
  endsequence

  a_wake_sources: assert property (((|p.din) || p.wake) && !rst_fall |=> s.awake)
    else $error("wake source did not wake");
  a_reset_sleep: assert property (rst_fall |=> !s.awake ##0 (s.cfg == lsc_pkg::CFG_RESET))
    else $error("reset fall did not enter sleep");
  a_reset_outputs_off: assert property (!p.rst_pin |=> (s.hs == 4'h0) && (s.fault_lat == 4'h0))
    else $error("outputs or faults alive under reset");
  a_fault_flag_drive: assert property (|p.fault && p.rst_pin |=> s.ff_oe && (s.fault_lat != 4'h0))
    else $error("fault flag not pulled low");
  a_select_tristate: assert property (p.cs_n |=> !s.sdo_oe)
    else $error("serial output driven while deselected");
  a_sense_commit: assert property (seq_sense_write |=>
      (o_current_sense_out_oe == $past(s.shift[lsc_pkg::SENSE_EN_BIT]))
      && (o_sense_temp == $past(s.shift[lsc_pkg::SENSE_TEMP_BIT])))
    else $error("sense write not committed");
  a_status_load: assert property (cs_fall |=> (s.sdo == $past(status[15])) && (s.sout == $past(status)))
    else $error("status not loaded on select fall");
  a_sample_falling: assert property (sclk_fall |=> s.shift[0] == $past(p.sdi))
    else $error("input bit not sampled on falling clock");
  a_short_frame: assert property (cs_rise && s.bitcnt != 5'h10 |=> $stable(s.cfg))
    else $error("short frame changed configuration");
  a_watchdog_start: assert property (rst_rise |=> s.wd_run && (s.wd_cnt == 32'h0))
    else $error("watchdog not started by reset rise");
  a_failsafe_follow: assert property (s.failsafe && s.awake && p.rst_pin |=> s.hs == $past(p.din))
    else $error("fail-safe outputs do not follow inputs");

endmodule // lsc_ctrl
`default_nettype wire

// ==== lsc_pkg.sv ====
// constants, field positions and carrier types of the lamp switch control block
// assumes a 250 MHz reference clock; all pins arrive asynchronous to it
package lsc_pkg;

  localparam int CLK_MHZ       = 250;
  localparam int FRAME_BITS    = 16;
  localparam int ADDR_MSB      = 15;
  localparam int ADDR_LSB      = 11;
  localparam int WDOG_TIME_US  = 100000;
  localparam int WDOG_CYCLES   = WDOG_TIME_US * CLK_MHZ;

  localparam logic [4:0] ADDR_OUT_CTRL = 5'h01;
  localparam logic [4:0] ADDR_SENSE    = 5'h02;
  localparam logic [4:0] ADDR_TRIP     = 5'h03;
  localparam logic [4:0] ADDR_INRUSH   = 5'h04;

  localparam int OUT_ON_LSB     = 0;
  localparam int OUT_DIRECT_LSB = 4;
  localparam int OUT_EXTCLK_BIT = 8;
  localparam int SENSE_CHAN_LSB = 0;
  localparam int SENSE_TEMP_BIT = 2;
  localparam int SENSE_EN_BIT   = 3;
  localparam int TRIP_LSB       = 0;
  localparam int INRUSH_LSB     = 0;

  typedef struct packed {
    logic [3:0] spi_on;
    logic [3:0] direct_sel;
    logic       ext_clk;
    logic [1:0] sense_chan;
    logic       sense_temp;
    logic       sense_en;
    logic [3:0] trip;
    logic [7:0] inrush;
  } lsc_cfg_t;

  localparam lsc_cfg_t CFG_RESET = '0;

  typedef struct packed {
    logic [3:0] din;
    logic       wake;
    logic       rst_pin;
    logic       cs_n;
    logic       sclk;
    logic       sdi;
    logic       fsi;
    logic [3:0] fault;
  } lsc_pins_t;

  typedef struct packed {
    lsc_cfg_t    cfg;
    logic        awake;
    logic        rst_prev;
    logic        sclk_prev;
    logic        cs_prev;
    logic [15:0] shift;
    logic [15:0] sout;
    logic [4:0]  bitcnt;
    logic        sdo;
    logic        sdo_oe;
    logic [3:0]  hs;
    logic        ff_oe;
    logic [3:0]  fault_lat;
    logic        wd_run;
    logic [31:0] wd_cnt;
    logic        failsafe;
    logic        pwm_clk;
  } lsc_state_t;

endpackage

// ==== lsc_sync.sv ====
// two-flop synchroniser for a bundle of asynchronous pins
// assumes each bit is independent; no multi-bit coherence is implied
`timescale 1ns/1ns
`default_nettype none
module lsc_sync
#(
  parameter int               WIDTH   = 1,
  // lets each pin come out of reset at its idle level, so no false edge follows
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      meta   <= RST_VAL;
      o_sync <= RST_VAL;
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule // lsc_sync
`default_nettype wire

// ==== lsc_host.sv ====
// serial master model standing in for the host microcontroller
// assumes the bench clock i_ref_clk; every pin moves just after its falling edge
`timescale 1ns/1ns
`default_nettype none
module lsc_host
(
  input  wire logic i_ref_clk,
  input  wire logic i_sdo,
  output var  logic o_cs_n,
  output var  logic o_sclk,
  output var  logic o_sdi
);
  // select idles high, clock and data idle low, as their pulls would leave them
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi  = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  // nbits below 16 makes a deliberately short frame
  task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = '0;
    o_cs_n = 1'b0;
    step(125);
    rx[15] = i_sdo;
    // 64 ns phases, 128 ns period: below the host's clock limit
    for (int k = 0; k < nbits; k++)
    begin
      o_sclk = 1'b1;
      o_sdi  = tx[15-k];
      step(16);
      if (k < 15)
        rx[14-k] = i_sdo;
      o_sclk = 1'b0;
      step(16);
    end
    // data drops to its pull-down level once the last bit is taken
    o_sdi = 1'b0;
    step(15);
    o_cs_n = 1'b1;
    step(250);
  endtask
endmodule // lsc_host
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench of the lamp switch control block
// assumes lsc_pkg, lsc_sync, lsc_ctrl and lsc_host are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); end end
module tb_top;
  localparam int WD = 2000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  din = '0;
  logic        wake = 1'b0;
  logic        rpin_n = 1'b0;
  logic        fsi = 1'b0;
  logic [3:0]  fault = '0;
  logic        cs_n, sclk, sdi;
  logic [3:0]  hs, trip;
  logic        ff_o, ff_oe, sdo, sdo_oe, temp, sns_oe, pwm, awake, fsafe;
  logic [1:0]  chan;
  logic [7:0]  inrush;
  logic [15:0] rx;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  // rows: {pad, control data[10:0], direct inputs, expected outputs, 3'b0, pwm clock}
  logic [23:0] rows [4] = '{24'h00A0A0, 24'h0F0550, 24'h03C1D0, 24'h110101};

  always #2 clk = ~clk;

  lsc_ctrl #(.WDOG_CYCLES(WD)) uut (.i_ref_clk(clk), .i_sys_rst(rst), .i_direct_input(din),
    .i_wake(wake), .i_reset_pin_n(rpin_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_sdi(sdi),
    .i_fsi(fsi), .i_fault(fault), .o_high_side_outputs(hs), .o_fault_flag_n_o(ff_o),
    .o_fault_flag_n_oe(ff_oe), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_sense_chan(chan),
    .o_sense_temp(temp), .o_current_sense_out_oe(sns_oe), .o_trip_level(trip),
    .o_inrush_time(inrush), .o_pwm_clk(pwm), .o_awake(awake), .o_failsafe(fsafe));

  // a released serial output shows the inverse of its last bit to the host
  lsc_host host (.i_ref_clk(clk), .i_sdo(sdo_oe ? sdo : ~sdo), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_sdi(sdi));

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [10:0] d, input int nb = 16);
    host.frame({a, d}, nb, rx);
  endtask

  task automatic finish_test();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    wt(10);
    rst = 1'b0;
    wt(2500);
    rpin_n = 1'b1;
    wt(1250);
    `CHK(awake, 1'b1)
    `CHK(sdo_oe, 1'b0)
    foreach (rows[i])
    begin
      din = rows[i][11:8];
      wr(lsc_pkg::ADDR_OUT_CTRL, rows[i][22:12]);
      `CHK(hs, rows[i][7:4])
      `CHK(pwm, rows[i][0])
    end
    din = '0;
    wr(lsc_pkg::ADDR_SENSE, 11'h00E);
    `CHK({chan, temp, sns_oe}, 4'hB)
    wr(lsc_pkg::ADDR_SENSE, 11'h000);
    `CHK(sns_oe, 1'b0)
    wr(lsc_pkg::ADDR_TRIP, 11'h009);
    wr(lsc_pkg::ADDR_INRUSH, 11'h05A);
    `CHK({trip, inrush}, 12'h95A)
    wr(5'h1F, 11'h7FF);
    wr(lsc_pkg::ADDR_TRIP, 11'h003, 15);
    `CHK(trip, 4'h9)
    fault = 4'h2;
    wt(6);
    `CHK({ff_oe, ff_o}, 2'h2)
    wr(5'h00, 11'h000);
    `CHK(rx[15:12], 4'h2)
    fault = '0;
    wt(6);
    `CHK(ff_oe, 1'b0)
    rpin_n = 1'b0;
    wt(2500);
    `CHK({awake, hs, trip}, 9'h000)
    wr(lsc_pkg::ADDR_TRIP, 11'h003);
    din = 4'h4;
    wt(6);
    `CHK({awake, hs, trip}, 9'h100)
    din = '0;
    rpin_n = 1'b1;
    wt(1250);
    rpin_n = 1'b0;
    wt(2500);
    `CHK(awake, 1'b0)
    wake = 1'b1;
    wt(6);
    `CHK(awake, 1'b1)
    wake = 1'b0;
    fsi = 1'b1;
    din = 4'h6;
    rpin_n = 1'b1;
    wt(10);
    `CHK({fsafe, hs}, 5'h00)
    // bounded wait for the watchdog to expire
    for (int k = 0; k < 2 * WD && fsafe !== 1'b1; k++)
      wt(1);
    if (fsafe !== 1'b1)
      n_mismatch++;
    else
    begin
      wt(2);
      `CHK(hs, 4'h6)
      wr(lsc_pkg::ADDR_TRIP, 11'h001);
      `CHK({fsafe, trip}, 5'h01)
    end
    fsi = 1'b0;
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
